/* File: logic/miagg_map.svh */
// Register offsets, field positions and limits of the interrupt aggregator
`ifndef MIAGG_MAP_SVH
`define MIAGG_MAP_SVH
`define MIAGG_ENABLE_OFS 8'h04
`define MIAGG_STATUS_OFS 8'h08
`define MIAGG_BE_NONE 4'hf
`define MIAGG_ZERO32 32'h0000_0000
`define MIAGG_EVT_RST 16'h0000
`define MIAGG_UPPER_ZERO 16'h0000
`define MIAGG_IRQ_N_RST 1'h1
`define MIAGG_SYS_ERR 0
`define MIAGG_PAR_ERR 1
`define MIAGG_RX_CHECK 2
`define MIAGG_RX_ABORT 3
`define MIAGG_RX_FORMAT 4
`define MIAGG_RX_OVERRUN 5
`define MIAGG_RX_SMALL_RD 6
`define MIAGG_RX_LARGE_RD 7
`define MIAGG_RX_READY_WR 8
`define MIAGG_RX_FREE_EMPTY 9
`define MIAGG_RX_READY_FULL 10
`define MIAGG_TX_FREE_WR 11
`define MIAGG_TX_READY_RD 12
`define MIAGG_TX_FREE_FULL 13
`define MIAGG_TX_DONE 14
`define MIAGG_TX_UNDERFLOW 15
`define MIAGG_ABORT_RUN 3'h7
`define MIAGG_RUN_RST 3'h0
`define MIAGG_MIN_BITS_CCITT 16'h0020
`define MIAGG_MIN_BITS_CRC32 16'h0030
`define MIAGG_OCTET_MASK 16'h0007
`endif

/* File: logic/miagg_pkg.sv */
// Types shared by the interrupt aggregator modules
package miagg_pkg;
   typedef logic [15:0] miagg_evt_t;
   typedef struct packed {
      miagg_evt_t enable_ff;
      miagg_evt_t status_ff;
      logic [31:0] rdata_ff;
      logic ack_ff;
      logic irq_n_ff;
   } miagg_top_s;
   typedef struct packed {
      logic [2:0] run_ff;
      logic evt_ff;
   } miagg_abort_s;
   typedef struct packed {
      logic evt_ff;
   } miagg_fmt_s;
endpackage : miagg_pkg

/* File: logic/miagg_rx_if.sv */
// Receive event carrier from the line checkers to the aggregator
`timescale 1ns/1ns
interface miagg_rx_if;
   logic abort_evt;
   logic format_evt;
   modport abort_src (output abort_evt);
   modport format_src (output format_evt);
   modport sink (input abort_evt, input format_evt);
endinterface : miagg_rx_if

/* File: logic/miagg_abort_det.sv */
// Abort detector: counts consecutive ones on the receive bit stream
`timescale 1ns/1ns
`include "miagg_map.svh"
module miagg_abort_det (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Receive bit stream
   input wire logic bit_valid,
   input wire logic bit_val,
   // Event out
   miagg_rx_if.abort_src evt_if
);
   miagg_pkg::miagg_abort_s st_ff;
   miagg_pkg::miagg_abort_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.evt_ff = 1'h0;
      if (bit_valid) begin
         if (!bit_val) begin
            nxt_st.run_ff = `MIAGG_RUN_RST;
         end else if (st_ff.run_ff != `MIAGG_ABORT_RUN) begin
            nxt_st.run_ff = st_ff.run_ff + 3'h1;
            nxt_st.evt_ff = (st_ff.run_ff == `MIAGG_ABORT_RUN - 3'h1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{run_ff: `MIAGG_RUN_RST, evt_ff: 1'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign evt_if.abort_evt = st_ff.evt_ff;
endmodule : miagg_abort_det

/* File: logic/miagg_fmt_chk.sv */
// Frame format checker: length limits and octet alignment
`timescale 1ns/1ns
`include "miagg_map.svh"
module miagg_fmt_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Frame summary at frame end
   input wire logic frame_end,
   input wire logic [15:0] frame_bits,
   input wire logic [15:0] max_bits,
   input wire logic crc32_sel,
   // Event out
   miagg_rx_if.format_src evt_if
);
   miagg_pkg::miagg_fmt_s st_ff;
   miagg_pkg::miagg_fmt_s nxt_st;
   logic [15:0] min_bits;

   always_comb begin
      min_bits = crc32_sel ? `MIAGG_MIN_BITS_CRC32 : `MIAGG_MIN_BITS_CCITT;
      nxt_st = st_ff;
      nxt_st.evt_ff = frame_end && ((frame_bits > max_bits) ||
         (frame_bits < min_bits) ||
         ((frame_bits & `MIAGG_OCTET_MASK) != 16'h0000));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{evt_ff: 1'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign evt_if.format_evt = st_ff.evt_ff;
endmodule : miagg_fmt_chk

/* File: logic/miagg_top.sv */
// Master interrupt aggregator: status, enable and host interrupt
`timescale 1ns/1ns
`include "miagg_map.svh"
module miagg_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // Host target register port
   input wire logic REG_SEL,
   input wire logic REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [3:0] BYTE_LANE_ENABLES_N,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_ACK,
   // Host interrupt
   output logic HOST_IRQ_N,
   // Host bus error events
   input wire logic ADDR_PAR_ERR,
   input wire logic SPECIAL_DATA_PAR_ERR,
   input wire logic MASTER_ABORT_RCVD,
   input wire logic TARGET_ABORT_DET,
   input wire logic MASTER_DATA_PAR_ERR,
   input wire logic PARITY_REPORT_N,
   // Receive line and frame checks
   input wire logic RX_BIT_VALID,
   input wire logic RX_BIT,
   input wire logic RX_CHECK_STROBE,
   input wire logic [31:0] RX_CHECK_RECEIVED,
   input wire logic [31:0] RX_CRC_RESIDUE,
   input wire logic RX_FRAME_END,
   input wire logic [15:0] RX_FRAME_BITS,
   input wire logic [15:0] RX_MAX_BITS,
   input wire logic RX_CRC32_SEL,
   // Receive FIFO and descriptor queues
   input wire logic RX_FIFO_WRITE,
   input wire logic RX_FIFO_FULL,
   input wire logic RX_SMALL_FREE_READ_DONE,
   input wire logic RX_LARGE_FREE_READ_DONE,
   input wire logic RX_READY_WRITE_DONE,
   input wire logic RX_DESC_FETCH,
   input wire logic RX_SMALL_FREE_EMPTY,
   input wire logic RX_LARGE_FREE_EMPTY,
   input wire logic RX_READY_WRITE,
   input wire logic RX_READY_FULL,
   // Transmit queues and FIFO
   input wire logic TX_FREE_WRITE_DONE,
   input wire logic TX_READY_READ_DONE,
   input wire logic TX_FREE_WRITE,
   input wire logic TX_FREE_FULL,
   input wire logic TX_PKT_DONE,
   input wire logic TX_NOTIFY_ON_DONE,
   input wire logic TX_FIFO_READ,
   input wire logic TX_FIFO_EMPTY
);
   miagg_pkg::miagg_top_s st_ff;
   miagg_pkg::miagg_top_s nxt_st;
   miagg_pkg::miagg_evt_t ev;
   logic acc_on;
   logic hit_en;
   logic hit_st;
   logic rd_clr;
   logic wr_en;

   miagg_rx_if rx_evt ();

   miagg_abort_det u_abort (
      .clk (MCLK),
      .rst_n (NRST),
      .bit_valid (RX_BIT_VALID),
      .bit_val (RX_BIT),
      .evt_if (rx_evt.abort_src)
   );

   miagg_fmt_chk u_fmt (
      .clk (MCLK),
      .rst_n (NRST),
      .frame_end (RX_FRAME_END),
      .frame_bits (RX_FRAME_BITS),
      .max_bits (RX_MAX_BITS),
      .crc32_sel (RX_CRC32_SEL),
      .evt_if (rx_evt.format_src)
   );

   assign acc_on = REG_SEL && (BYTE_LANE_ENABLES_N != `MIAGG_BE_NONE);
   assign hit_en = (REG_ADDR == `MIAGG_ENABLE_OFS);
   assign hit_st = (REG_ADDR == `MIAGG_STATUS_OFS);
   assign rd_clr = acc_on && !REG_WR && hit_st;
   assign wr_en = acc_on && REG_WR && hit_en;

   // Event vector in status bit order
   always_comb begin
      ev = `MIAGG_EVT_RST;
      ev[`MIAGG_SYS_ERR] = ADDR_PAR_ERR || SPECIAL_DATA_PAR_ERR ||
         MASTER_ABORT_RCVD || TARGET_ABORT_DET;
      ev[`MIAGG_PAR_ERR] = MASTER_DATA_PAR_ERR || !PARITY_REPORT_N;
      ev[`MIAGG_RX_CHECK] = RX_CHECK_STROBE &&
         (RX_CHECK_RECEIVED != RX_CRC_RESIDUE);
      ev[`MIAGG_RX_ABORT] = rx_evt.abort_evt;
      ev[`MIAGG_RX_FORMAT] = rx_evt.format_evt;
      ev[`MIAGG_RX_OVERRUN] = RX_FIFO_WRITE && RX_FIFO_FULL;
      ev[`MIAGG_RX_SMALL_RD] = RX_SMALL_FREE_READ_DONE;
      ev[`MIAGG_RX_LARGE_RD] = RX_LARGE_FREE_READ_DONE;
      ev[`MIAGG_RX_READY_WR] = RX_READY_WRITE_DONE;
      ev[`MIAGG_RX_FREE_EMPTY] = RX_DESC_FETCH && RX_SMALL_FREE_EMPTY &&
         RX_LARGE_FREE_EMPTY;
      ev[`MIAGG_RX_READY_FULL] = RX_READY_WRITE && RX_READY_FULL;
      ev[`MIAGG_TX_FREE_WR] = TX_FREE_WRITE_DONE;
      ev[`MIAGG_TX_READY_RD] = TX_READY_READ_DONE;
      ev[`MIAGG_TX_FREE_FULL] = TX_FREE_WRITE && TX_FREE_FULL;
      ev[`MIAGG_TX_DONE] = TX_PKT_DONE && TX_NOTIFY_ON_DONE;
      ev[`MIAGG_TX_UNDERFLOW] = TX_FIFO_READ && TX_FIFO_EMPTY;
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack_ff = REG_SEL;
      nxt_st.status_ff = st_ff.status_ff | ev;
      if (rd_clr) begin
         nxt_st.status_ff = ev;
      end
      if (wr_en) begin
         nxt_st.enable_ff = REG_WDATA[15:0];
      end
      if (REG_SEL && !REG_WR) begin
         nxt_st.rdata_ff = `MIAGG_ZERO32;
         if (acc_on && hit_en) begin
            nxt_st.rdata_ff = {`MIAGG_UPPER_ZERO, st_ff.enable_ff};
         end
         if (rd_clr) begin
            nxt_st.rdata_ff = {`MIAGG_UPPER_ZERO, st_ff.status_ff};
         end
      end
      nxt_st.irq_n_ff = ~|(nxt_st.status_ff & nxt_st.enable_ff);
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         st_ff <= '{enable_ff: `MIAGG_EVT_RST,
                    status_ff: `MIAGG_EVT_RST,
                    rdata_ff: `MIAGG_ZERO32,
                    ack_ff: 1'h0,
                    irq_n_ff: `MIAGG_IRQ_N_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign REG_RDATA = st_ff.rdata_ff;
   assign REG_ACK = st_ff.ack_ff;
   assign HOST_IRQ_N = st_ff.irq_n_ff;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!NRST);

   // Steps of a status read, of an abort run and of an access with all lanes off
   sequence status_read_s;
      rd_clr && (ev == `MIAGG_EVT_RST);
   endsequence

   sequence run_start_s;
      RX_BIT_VALID && !RX_BIT;
   endsequence

   sequence seven_ones_s;
      (RX_BIT_VALID && RX_BIT) [*7];
   endsequence

   sequence lanes_off_s;
      REG_SEL && (BYTE_LANE_ENABLES_N == `MIAGG_BE_NONE);
   endsequence

   read_clears_a: assert property (
      status_read_s |=> (st_ff.status_ff == `MIAGG_EVT_RST) && HOST_IRQ_N)
      else $error("status not cleared by read");

   read_returns_a: assert property (
      rd_clr |=> REG_ACK && (REG_RDATA[15:0] == $past(st_ff.status_ff)))
      else $error("status read data wrong");

   // event in the clearing cycle survives
   set_wins_a: assert property (
      rd_clr && (ev != `MIAGG_EVT_RST) |=>
         (st_ff.status_ff == $past(ev)))
      else $error("event lost during read clear");

   lanes_off_a: assert property (
      lanes_off_s |=> $stable(st_ff.enable_ff) &&
         ((st_ff.status_ff & $past(st_ff.status_ff)) ==
         $past(st_ff.status_ff)))
      else $error("access made with all lanes off");

   poll_masked_a: assert property (
      (ev != `MIAGG_EVT_RST) |=> ((st_ff.status_ff & $past(ev)) == $past(ev)))
      else $error("event not latched");

   sys_err_a: assert property (
      MASTER_ABORT_RCVD || TARGET_ABORT_DET |=>
         st_ff.status_ff[`MIAGG_SYS_ERR])
      else $error("system error bit not set");

   parity_report_a: assert property (
      !PARITY_REPORT_N |=> st_ff.status_ff[`MIAGG_PAR_ERR])
      else $error("parity bit not set");

   check_err_a: assert property (
      RX_CHECK_STROBE && (RX_CHECK_RECEIVED != RX_CRC_RESIDUE) |=>
         st_ff.status_ff[`MIAGG_RX_CHECK])
      else $error("check error bit not set");

   // seven ones after a zero raise abort
   abort_run_a: assert property (
      run_start_s ##1 seven_ones_s |-> ##2 st_ff.status_ff[`MIAGG_RX_ABORT])
      else $error("abort bit not set after run");

   format_err_a: assert property (
      RX_FRAME_END && ((RX_FRAME_BITS & `MIAGG_OCTET_MASK) != 16'h0000) |->
         ##2 st_ff.status_ff[`MIAGG_RX_FORMAT])
      else $error("format bit not set");

   overrun_a: assert property (
      RX_FIFO_WRITE && RX_FIFO_FULL |=> st_ff.status_ff[`MIAGG_RX_OVERRUN])
      else $error("overrun bit not set");

   free_empty_a: assert property (
      RX_DESC_FETCH && RX_SMALL_FREE_EMPTY && RX_LARGE_FREE_EMPTY |=>
         st_ff.status_ff[`MIAGG_RX_FREE_EMPTY])
      else $error("free queue error bit not set");

   tx_done_a: assert property (
      TX_PKT_DONE && TX_NOTIFY_ON_DONE |=> st_ff.status_ff[`MIAGG_TX_DONE])
      else $error("transmit done bit not set");

   underflow_a: assert property (
      TX_FIFO_READ && TX_FIFO_EMPTY |=>
         st_ff.status_ff[`MIAGG_TX_UNDERFLOW])
      else $error("underflow bit not set");

   upper_zero_a: assert property (
      REG_ACK |-> (REG_RDATA[31:16] == `MIAGG_UPPER_ZERO))
      else $error("upper status bits not zero");

   enable_write_a: assert property (
      wr_en ##1 !REG_SEL ##1
         (REG_SEL && !REG_WR && hit_en && acc_on) |=>
         (REG_RDATA[15:0] == $past(st_ff.enable_ff)) &&
         (st_ff.enable_ff == $past(REG_WDATA[15:0], 3)))
      else $error("enable word not written");

   irq_raise_a: assert property (
      ((ev & st_ff.enable_ff) != `MIAGG_EVT_RST) && !wr_en |=> !HOST_IRQ_N)
      else $error("interrupt not asserted");

   irq_masked_a: assert property (
      (st_ff.enable_ff == `MIAGG_EVT_RST) && !wr_en |=> HOST_IRQ_N)
      else $error("interrupt asserted while masked");

   whole_word_a: assert property (
      wr_en |=> (st_ff.enable_ff == $past(REG_WDATA[15:0])))
      else $error("enable word not fully written");

   bus_parity_a: assert property (
      ADDR_PAR_ERR || SPECIAL_DATA_PAR_ERR |=>
         st_ff.status_ff[`MIAGG_SYS_ERR])
      else $error("system error bit not set by parity");

   master_parity_a: assert property (
      MASTER_DATA_PAR_ERR |=> st_ff.status_ff[`MIAGG_PAR_ERR])
      else $error("parity bit not set by master error");

   long_frame_a: assert property (
      RX_FRAME_END && (RX_FRAME_BITS > RX_MAX_BITS) |->
         ##2 st_ff.status_ff[`MIAGG_RX_FORMAT])
      else $error("long frame not flagged");

   short_frame_a: assert property (
      RX_FRAME_END && RX_CRC32_SEL &&
         (RX_FRAME_BITS < `MIAGG_MIN_BITS_CRC32) |->
         ##2 st_ff.status_ff[`MIAGG_RX_FORMAT])
      else $error("short frame not flagged");

   small_read_a: assert property (
      RX_SMALL_FREE_READ_DONE |=> st_ff.status_ff[`MIAGG_RX_SMALL_RD])
      else $error("small queue bit not set");

   large_read_a: assert property (
      RX_LARGE_FREE_READ_DONE |=> st_ff.status_ff[`MIAGG_RX_LARGE_RD])
      else $error("large queue bit not set");

   ready_write_a: assert property (
      RX_READY_WRITE_DONE |=> st_ff.status_ff[`MIAGG_RX_READY_WR])
      else $error("ready queue bit not set");

   ready_full_a: assert property (
      RX_READY_WRITE && RX_READY_FULL |=>
         st_ff.status_ff[`MIAGG_RX_READY_FULL])
      else $error("ready queue error bit not set");

   tx_free_wr_a: assert property (
      TX_FREE_WRITE_DONE |=> st_ff.status_ff[`MIAGG_TX_FREE_WR])
      else $error("transmit free queue bit not set");

   tx_ready_rd_a: assert property (
      TX_READY_READ_DONE |=> st_ff.status_ff[`MIAGG_TX_READY_RD])
      else $error("transmit ready queue bit not set");

   tx_free_full_a: assert property (
      TX_FREE_WRITE && TX_FREE_FULL |=>
         st_ff.status_ff[`MIAGG_TX_FREE_FULL])
      else $error("transmit free queue error bit not set");

endmodule : miagg_top

/* File: tb/miagg_host.sv */
// Host model: register accesses on the target port
`timescale 1ns/1ns
module miagg_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic reg_sel,
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [3:0] lanes_n,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack
);
   initial begin
      reg_sel = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'h5a;
      lanes_n = 4'hf;
      reg_wdata = 32'ha5a5_a5a5;
   end

   // One-cycle request, answer read in the cycle after
   task acc(input logic wr, input logic [7:0] a, input logic [3:0] ln,
      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      @(posedge clk);
      #1;
      reg_sel = 1'b1;
      reg_wr = wr;
      reg_addr = a;
      lanes_n = ln;
      reg_wdata = wd;
      @(posedge clk);
      #1;
      reg_sel = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~wd;
      lanes_n = ~ln;
      ok = reg_ack;
      rd = reg_rdata;
   endtask : acc
endmodule : miagg_host

/* File: tb/tb_top.sv */
// Self-checking bench of the interrupt aggregator
`timescale 1ns/1ns
module tb_top;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic sel, wr, ack;
   logic [7:0] addr;
   logic [3:0] ln;
   logic [31:0] wd, rdat;
   logic irq_n;
   logic ape, sdpe, mab, tab, mdpe, prn;
   logic bval, bit_v, cstb, fend, c32;
   logic [31:0] crx, cres;
   logic [15:0] fbits, mxb;
   logic fwr, ffull, sfr, lfr, rwd, fetch, sem, lem, rwr, rfull;
   logic tfwd, trrd, tfw, tff, pdone, note, frd, femp;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   always #2 mclk = ~mclk;

   miagg_host miagg_host_i (.clk(mclk), .reg_sel(sel), .reg_wr(wr),
      .reg_addr(addr), .lanes_n(ln), .reg_wdata(wd), .reg_rdata(rdat),
      .reg_ack(ack));

   miagg_top miagg_top_i (.MCLK(mclk), .NRST(nrst), .REG_SEL(sel),
      .REG_WR(wr), .REG_ADDR(addr), .BYTE_LANE_ENABLES_N(ln),
      .REG_WDATA(wd), .REG_RDATA(rdat), .REG_ACK(ack), .HOST_IRQ_N(irq_n),
      .ADDR_PAR_ERR(ape), .SPECIAL_DATA_PAR_ERR(sdpe),
      .MASTER_ABORT_RCVD(mab), .TARGET_ABORT_DET(tab),
      .MASTER_DATA_PAR_ERR(mdpe), .PARITY_REPORT_N(prn),
      .RX_BIT_VALID(bval), .RX_BIT(bit_v), .RX_CHECK_STROBE(cstb),
      .RX_CHECK_RECEIVED(crx), .RX_CRC_RESIDUE(cres), .RX_FRAME_END(fend),
      .RX_FRAME_BITS(fbits), .RX_MAX_BITS(mxb), .RX_CRC32_SEL(c32),
      .RX_FIFO_WRITE(fwr), .RX_FIFO_FULL(ffull),
      .RX_SMALL_FREE_READ_DONE(sfr), .RX_LARGE_FREE_READ_DONE(lfr),
      .RX_READY_WRITE_DONE(rwd), .RX_DESC_FETCH(fetch),
      .RX_SMALL_FREE_EMPTY(sem), .RX_LARGE_FREE_EMPTY(lem),
      .RX_READY_WRITE(rwr), .RX_READY_FULL(rfull),
      .TX_FREE_WRITE_DONE(tfwd), .TX_READY_READ_DONE(trrd),
      .TX_FREE_WRITE(tfw), .TX_FREE_FULL(tff), .TX_PKT_DONE(pdone),
      .TX_NOTIFY_ON_DONE(note), .TX_FIFO_READ(frd), .TX_FIFO_EMPTY(femp));

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk

   task rd(input logic [7:0] a, input logic [3:0] l, input logic [31:0] exp);
      logic [31:0] d;
      logic ok;
      miagg_host_i.acc(1'b0, a, l, 32'h0000_0000, d, ok);
      chk("ack", 32'h0000_0001, {31'h0, ok});
      chk("read data", exp, d);
   endtask : rd

   task wrt(input logic [7:0] a, input logic [3:0] l, input logic [31:0] v);
      logic [31:0] d;
      logic ok;
      miagg_host_i.acc(1'b1, a, l, v, d, ok);
      chk("ack", 32'h0000_0001, {31'h0, ok});
   endtask : wrt

   task idle_evt;
      {ape, sdpe, mab, tab, mdpe, cstb, fend, c32, bval, bit_v} = 10'h000;
      {fwr, ffull, sfr, lfr, rwd, fetch, sem, lem, rwr, rfull} = 10'h000;
      {tfwd, trrd, tfw, tff, pdone, note, frd, femp} = 8'h00;
      prn = 1'b1;
      crx = 32'h0000_0000;
      cres = 32'h0000_0000;
      fbits = 16'h0030;
      mxb = 16'h0038;
   endtask : idle_evt

   // Drives one event kind for its cycle(s), or only near misses for index 20, then goes idle
   task evt(input int i);
      @(posedge mclk);
      #1;
      case (i)
         0: ape = 1'b1;
         1: mdpe = 1'b1;
         2: begin
            cstb = 1'b1;
            crx = 32'h1234_5678;
            cres = 32'h1234_5679;
         end
         3: begin
            {bval, bit_v} = 2'b10;
            @(posedge mclk);
            #1;
            bit_v = 1'b1;
            repeat (6) @(posedge mclk);
         end
         4: {fend, fbits} = {1'b1, 16'h0040};
         5: {fwr, ffull} = 2'b11;
         6: sfr = 1'b1;
         7: lfr = 1'b1;
         8: rwd = 1'b1;
         9: {fetch, sem, lem} = 3'b111;
         10: {rwr, rfull} = 2'b11;
         11: tfwd = 1'b1;
         12: trrd = 1'b1;
         13: {tfw, tff} = 2'b11;
         14: {pdone, note} = 2'b11;
         15: {frd, femp} = 2'b11;
         16: sdpe = 1'b1;
         17: mab = 1'b1;
         18: tab = 1'b1;
         19: prn = 1'b0;
         default: begin
            {fwr, fetch, sem, rwr, tfw, pdone, frd, cstb} = 8'hff;
            {bval, bit_v} = 2'b10;
            @(posedge mclk);
            #1;
            bit_v = 1'b1;
            repeat (6) @(posedge mclk);
            #1;
            bit_v = 1'b0;
         end
      endcase
      @(posedge mclk);
      #1;
      idle_evt();
   endtask : evt

   task t_reset;
      chk("irq idle", 32'h0000_0001, {31'h0, irq_n});
      rd(8'h04, 4'h0, 32'h0000_0000);
      rd(8'h08, 4'h0, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset

   task t_events;
      int b;
      for (int i = 0; i < 21; i++) begin
         b = (i < 16) ? i : ((i == 19) ? 1 : 0);
         evt(i);
         repeat (2) @(posedge mclk);
         chk("masked irq", 32'h0000_0001, {31'h0, irq_n});
         // Index 20 holds only near misses, so nothing may latch
         rd(8'h08, 4'h0, (i == 20) ? 32'h0000_0000 :
            32'h0000_0001 << b);
      end
      rd(8'h08, 4'h0, 32'h0000_0000);
      $display("test events done");
   endtask : t_events

   task t_format;
      logic [16:0] tbl [6] = '{17'h1_0030, 17'h0_0020, 17'h0_0038,
         17'h0_001f, 17'h1_0028, 17'h0_0018};
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         #1;
         {c32, fbits} = tbl[i];
         fend = 1'b1;
         @(posedge mclk);
         #1;
         idle_evt();
         repeat (2) @(posedge mclk);
         rd(8'h08, 4'h0, (i < 3) ? 32'h0000_0000 : 32'h0000_0010);
      end
      // Lowered maximum makes an aligned frame too long
      @(posedge mclk);
      #1;
      {mxb, fbits, fend} = {16'h0028, 16'h0030, 1'b1};
      @(posedge mclk);
      #1;
      idle_evt();
      repeat (2) @(posedge mclk);
      rd(8'h08, 4'h0, 32'h0000_0010);
      $display("test format done");
   endtask : t_format

   task t_irq;
      wrt(8'h04, 4'h5, 32'hffff_8001);
      rd(8'h04, 4'h0, 32'h0000_8001);
      evt(1);
      chk("irq masked", 32'h0000_0001, {31'h0, irq_n});
      evt(15);
      chk("irq set", 32'h0000_0000, {31'h0, irq_n});
      rd(8'h08, 4'h0, 32'h0000_8002);
      chk("irq clear", 32'h0000_0001, {31'h0, irq_n});
      $display("test irq done");
   endtask : t_irq

   task t_lanes;
      wrt(8'h04, 4'hf, 32'h0000_ffff);
      rd(8'h04, 4'h0, 32'h0000_8001);
      evt(2);
      rd(8'h08, 4'hf, 32'h0000_0000);
      wrt(8'h08, 4'h0, 32'h0000_0000);
      rd(8'h08, 4'h0, 32'h0000_0004);
      rd(8'h0c, 4'h0, 32'h0000_0000);
      wrt(8'h04, 4'h7, 32'h0000_0000);
      rd(8'h04, 4'he, 32'h0000_0000);
      $display("test lanes done");
   endtask : t_lanes

   // Reset in mid-run clears enable, status and interrupt
   task t_rst_mid;
      wrt(8'h04, 4'h0, 32'h0000_0004);
      evt(2);
      chk("irq before reset", 32'h0000_0000, {31'h0, irq_n});
      nrst = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      nrst = 1'b1;
      chk("irq after reset", 32'h0000_0001, {31'h0, irq_n});
      rd(8'h04, 4'h0, 32'h0000_0000);
      rd(8'h08, 4'h0, 32'h0000_0000);
      $display("test mid reset done");
   endtask : t_rst_mid

   task close_out;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // Run is a few hundred cycles; ceiling leaves wide margin
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      idle_evt();
      repeat (4) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_events();
      t_format();
      t_irq();
      t_lanes();
      t_rst_mid();
      close_out();
   end
endmodule : tb_top
